// *** vsl_regs.svh ***
`ifndef VSL_REGS_SVH
`define VSL_REGS_SVH
// ****************************************
// format codes
// ****************************************
`define VSL_FMT_VESA 4'h0
`define VSL_FMT_1080I 4'h1
`define VSL_FMT_525I 4'h2
// ****************************************
// fixed durations in pixel periods
// ****************************************
`define VSL_T1 12'h001
`define VSL_T2 12'h002
`define VSL_T3 12'h003
`define VSL_T4 12'h004
// ****************************************
// frame and field sizes
// ****************************************
`define VSL_HD_FRAME 11'h465
`define VSL_HD_FIELD 11'h233
`define VSL_SD_FRAME 11'h20D
`define VSL_SD_FIELD 11'h107
// ****************************************
// breakpoint tables, first entry leftmost
// ****************************************
`define VSL_HD_BP_N 11
`define VSL_SD_BP_N 15
`define VSL_HD_BPS {11'h006, 11'h007, 11'h015, 11'h231, 11'h233, 11'h234, 11'h238, \
  11'h239, 11'h248, 11'h464, 11'h466}
`define VSL_SD_BPS {11'h004, 11'h007, 11'h00A, 11'h014, 11'h107, 11'h108, 11'h10A, \
  11'h10B, 11'h10D, 11'h10E, 11'h110, 11'h111, 11'h11A, 11'h11B, 11'h20E}
// ****************************************
// states, offsets and reset values
// ****************************************
`define VSL_ST_FIRST 4'h1
`define VSL_ST_PASS4 4'h4
`define VSL_ST_PASS 4'h5
`define VSL_HD_LAST 4'h9
`define VSL_SD_LAST 4'h7
`define VSL_SD_EQ_LAST 4'hC
`define VSL_OFFSET 11'h0C8
`define VSL_LINE_RST 11'h001
`endif

// *** vsl_pkg.sv ***
package vsl_pkg;
  typedef enum logic [1:0] {
    MODE_VESA = 2'b00,
    MODE_HD = 2'b01,
    MODE_SD = 2'b10
  } vsl_mode_e;
  typedef enum logic [4:0] {
    HD_BROAD_BROAD = 5'b00000, HD_SYNC_SYNC = 5'b00001, HD_SYNC_BROAD = 5'b00010,
    HD_BROAD_SYNC = 5'b00011, HD_FULL_SYNC = 5'b00100, HD_FULL_BROAD = 5'b00101,
    HD_ACTIVE = 5'b00110, SD_EQ_EQ = 5'b01000, SD_BROAD_BROAD = 5'b01001,
    SD_EQ_BROAD = 5'b01010, SD_BROAD_EQ = 5'b01011, SD_FULL_EQ = 5'b01100,
    SD_FULL_BROAD = 5'b01101, SD_FULL_SYNC = 5'b01110, SD_SYNC_THEN_PICTURE = 5'b01111,
    SD_PICTURE_THEN_EQ = 5'b10000, SD_ACTIVE = 5'b10001
  } vsl_ltype_e;
  typedef struct packed {
    logic [9:0] luma;
    logic [9:0] cb;
    logic [9:0] cr;
  } vsl_video_s;
  typedef struct packed {
    logic [10:0] ch0;
    logic [10:0] ch1;
    logic [10:0] ch2;
  } vsl_dac_s;
  typedef struct packed {
    logic [10:0] blank;
    logic [10:0] low;
    logic [10:0] high;
  } vsl_amp_s;
  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
    logic [11:0] c;
    logic [11:0] d;
    logic [11:0] e;
    logic [11:0] g;
    logic [11:0] k;
    logic [11:0] k1;
    logic [11:0] total;
  } vsl_hparam_s;
  parameter vsl_ltype_e HD_LT [11] = '{HD_BROAD_BROAD, HD_SYNC_SYNC, HD_FULL_SYNC,
    HD_ACTIVE, HD_FULL_SYNC, HD_SYNC_BROAD, HD_BROAD_BROAD, HD_BROAD_SYNC,
    HD_FULL_SYNC, HD_ACTIVE, HD_FULL_SYNC};
  parameter vsl_ltype_e SD_LT [15] = '{SD_EQ_EQ, SD_BROAD_BROAD, SD_EQ_EQ,
    SD_FULL_SYNC, SD_ACTIVE, SD_PICTURE_THEN_EQ, SD_EQ_EQ, SD_EQ_BROAD,
    SD_BROAD_BROAD, SD_BROAD_EQ, SD_EQ_EQ, SD_FULL_EQ, SD_FULL_SYNC,
    SD_SYNC_THEN_PICTURE, SD_ACTIVE};
endpackage : vsl_pkg

// *** vsl_line_sequencer.sv ***
`include "vsl_regs.svh"
module vsl_line_sequencer #(
  parameter int LINE_W = 11,
  parameter int PIX_W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire logic [3:0] format_select,
  input wire logic vbi_video_pass_enable,
  input wire logic rgb_offset_select,
  input wire logic fullscale_range_select,
  input wire vsl_pkg::vsl_hparam_s hparam,
  input wire vsl_pkg::vsl_amp_s luma_amp,
  input wire vsl_pkg::vsl_amp_s chroma_amp,
  // timing references from the counter sync
  input wire logic line_start,
  input wire logic frame_start,
  // upstream video
  input wire vsl_pkg::vsl_video_s video_in,
  // converter side
  output vsl_pkg::vsl_dac_s dac_out,
  output logic fullscale_range_out,
  // status
  output vsl_pkg::vsl_ltype_e line_type,
  output logic [3:0] sync_state,
  output logic field_second
);
  // ****************************************
  // lookup and duration functions
  // ****************************************
  localparam logic [`VSL_HD_BP_N*11-1:0] HD_BPS = `VSL_HD_BPS;
  localparam logic [`VSL_SD_BP_N*11-1:0] SD_BPS = `VSL_SD_BPS;

  // first entry whose breakpoint lies above the line
  function automatic vsl_pkg::vsl_ltype_e hd_lookup(input logic [10:0] ln);
    vsl_pkg::vsl_ltype_e t;
    t = vsl_pkg::HD_FULL_SYNC;
    for (int i = `VSL_HD_BP_N - 1; i >= 0; i--)
    begin
      if (ln < HD_BPS[(`VSL_HD_BP_N - 1 - i)*11 +: 11])
        t = vsl_pkg::HD_LT[i];
    end
    return t;
  endfunction : hd_lookup

  function automatic vsl_pkg::vsl_ltype_e sd_lookup(input logic [10:0] ln);
    vsl_pkg::vsl_ltype_e t;
    t = vsl_pkg::SD_ACTIVE;
    for (int i = `VSL_SD_BP_N - 1; i >= 0; i--)
    begin
      if (ln < SD_BPS[(`VSL_SD_BP_N - 1 - i)*11 +: 11])
        t = vsl_pkg::SD_LT[i];
    end
    return t;
  endfunction : sd_lookup

  // state duration in pixel periods, never below one
  function automatic logic [11:0] dur_of(input vsl_pkg::vsl_mode_e m,
    input vsl_pkg::vsl_ltype_e t, input logic [3:0] s, input vsl_pkg::vsl_hparam_s h);
    logic [11:0] d;
    d = `VSL_T1;
    if (m == vsl_pkg::MODE_HD)
    begin
      case (s)
        4'h1: d = `VSL_T2;
        4'h2: d = h.c - `VSL_T4;
        4'h3: d = `VSL_T4;
        4'h4: d = h.e - h.c - `VSL_T2;
        4'h5: d = h.total - h.e - h.b;
        4'h6: d = h.b - h.a - `VSL_T2;
        4'h7: d = `VSL_T4;
        4'h8: d = h.a - `VSL_T4;
        default: d = `VSL_T2;
      endcase
    end
    else if (t == vsl_pkg::SD_PICTURE_THEN_EQ)
    begin
      case (s)
        4'h2: d = h.a;
        4'h3: d = `VSL_T2;
        4'h4: d = h.d - h.a - `VSL_T3;
        4'h5: d = h.g - h.d - h.k1;
        4'h6: d = h.k - `VSL_T1;
        4'h9: d = h.c;
        4'hA: d = `VSL_T2;
        4'hB: d = h.g - h.c - `VSL_T4;
        default: d = `VSL_T1;
      endcase
    end
    else
    begin
      case (s)
        4'h2: d = h.a;
        4'h3: d = `VSL_T2;
        4'h4: d = h.d - h.a - `VSL_T3;
        4'h5: d = h.total - h.d - h.k;
        4'h6: d = h.k - `VSL_T1;
        default: d = `VSL_T1;
      endcase
    end
    if (d == 12'h000)
      d = `VSL_T1;
    return d;
  endfunction : dur_of

  // ****************************************
  // format decode
  // ****************************************
  vsl_pkg::vsl_mode_e mode_reg;
  vsl_pkg::vsl_mode_e mode_next;
  logic [10:0] frame_w;
  logic [10:0] field_w;

  // preset selection from the format code
  assign mode_next = (format_select == `VSL_FMT_1080I) ? vsl_pkg::MODE_HD :
    (format_select == `VSL_FMT_525I) ? vsl_pkg::MODE_SD : vsl_pkg::MODE_VESA;
  assign frame_w = (mode_reg == vsl_pkg::MODE_HD) ? `VSL_HD_FRAME : `VSL_SD_FRAME;
  assign field_w = (mode_reg == vsl_pkg::MODE_HD) ? `VSL_HD_FIELD : `VSL_SD_FIELD;

  // ****************************************
  // line counter and line type
  // ****************************************
  logic [LINE_W-1:0] line_reg;
  logic [LINE_W-1:0] line_next;
  vsl_pkg::vsl_ltype_e ltype_reg;
  vsl_pkg::vsl_ltype_e ltype_next;
  logic field2_reg;
  logic field2_next;

  // wrap at frame size, frame start forces line one
  assign line_next = frame_start ? `VSL_LINE_RST :
    !line_start ? line_reg :
    (line_reg >= frame_w) ? `VSL_LINE_RST : line_reg + 11'h001;
  assign ltype_next = !(line_start || frame_start) ? ltype_reg :
    (mode_reg == vsl_pkg::MODE_HD) ? hd_lookup(line_next) : sd_lookup(line_next);
  assign field2_next = line_next > field_w;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_reg <= vsl_pkg::MODE_VESA;
      line_reg <= `VSL_LINE_RST;
      ltype_reg <= vsl_pkg::HD_BROAD_BROAD;
      field2_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      line_reg <= line_next;
      ltype_reg <= ltype_next;
      field2_reg <= field2_next;
    end
  end

  // ****************************************
  // horizontal state sequencer
  // ****************************************
  logic [PIX_W-1:0] hcount_reg;
  logic [PIX_W-1:0] hcount_next;
  logic [11:0] bnd_reg;
  logic [11:0] bnd_next;
  logic [3:0] state_reg;
  logic [3:0] state_next;
  logic [3:0] last_w;
  logic adv_w;
  logic restart_w;

  // pixel counter marks every state boundary
  assign restart_w = line_start || frame_start;
  assign last_w = (mode_reg == vsl_pkg::MODE_HD) ? `VSL_HD_LAST :
    (ltype_reg == vsl_pkg::SD_PICTURE_THEN_EQ) ? `VSL_SD_EQ_LAST : `VSL_SD_LAST;
  assign hcount_next = restart_w ? 12'h000 : hcount_reg + 12'h001;
  assign adv_w = !restart_w && (hcount_next == bnd_reg) && (state_reg < last_w);
  assign state_next = restart_w ? `VSL_ST_FIRST : adv_w ? state_reg + 4'h1 : state_reg;
  assign bnd_next = restart_w ? dur_of(mode_reg, ltype_next, `VSL_ST_FIRST, hparam) :
    adv_w ? bnd_reg + dur_of(mode_reg, ltype_reg, state_next, hparam) : bnd_reg;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hcount_reg <= 12'h000;
      bnd_reg <= 12'h001;
      state_reg <= 4'h1;
    end
    else
    begin
      hcount_reg <= hcount_next;
      bnd_reg <= bnd_next;
      state_reg <= state_next;
    end
  end

  // ****************************************
  // generated level and pass decision
  // ****************************************
  logic lvl_low_w;
  logic lvl_high_w;
  logic st5_w;
  logic sd_pic_w;
  logic pass_w;

  // hd: positive half after line start, negative half before the next
  // sd: negative sync from line start, eq pulse in second half of SD_PICTURE_THEN_EQ lines
  assign lvl_high_w = (mode_reg == vsl_pkg::MODE_HD) && (state_reg == `VSL_ST_FIRST);
  assign lvl_low_w = (mode_reg == vsl_pkg::MODE_HD) ? (state_reg == `VSL_HD_LAST) :
    (state_reg <= 4'h2) ||
    ((ltype_reg == vsl_pkg::SD_PICTURE_THEN_EQ) && (state_reg == 4'h8 || state_reg == 4'h9));
  assign st5_w = state_reg == `VSL_ST_PASS;
  assign sd_pic_w = (ltype_reg == vsl_pkg::SD_SYNC_THEN_PICTURE) ||
    (ltype_reg == vsl_pkg::SD_PICTURE_THEN_EQ) || (ltype_reg == vsl_pkg::SD_ACTIVE);
  assign pass_w = (mode_reg == vsl_pkg::MODE_VESA) ||
    ((mode_reg == vsl_pkg::MODE_HD) && st5_w && ((ltype_reg == vsl_pkg::HD_ACTIVE) ||
    ((ltype_reg == vsl_pkg::HD_FULL_SYNC) && vbi_video_pass_enable))) ||
    ((mode_reg == vsl_pkg::MODE_SD) && ((sd_pic_w && st5_w) ||
    ((ltype_reg == vsl_pkg::SD_FULL_SYNC) && vbi_video_pass_enable &&
    (st5_w || state_reg == `VSL_ST_PASS4))));

  // ****************************************
  // output multiplexer and offset
  // ****************************************
  logic [10:0] gen_luma_w;
  logic [10:0] gen_chroma_w;
  logic [10:0] ch0_w;
  logic [10:0] ch1_w;
  logic [10:0] ch2_w;
  logic [10:0] coff_w;
  vsl_pkg::vsl_dac_s dac_next;
  vsl_pkg::vsl_dac_s dac_reg;
  logic fs_reg;

  // programmed amplitudes stand in for video
  assign gen_luma_w = lvl_low_w ? luma_amp.low : lvl_high_w ? luma_amp.high :
    luma_amp.blank;
  assign gen_chroma_w = lvl_low_w ? chroma_amp.low : lvl_high_w ? chroma_amp.high :
    chroma_amp.blank;
  assign ch0_w = pass_w ? {1'b0, video_in.luma} : gen_luma_w;
  assign ch1_w = pass_w ? {1'b0, video_in.cb} : gen_chroma_w;
  assign ch2_w = pass_w ? {1'b0, video_in.cr} : gen_chroma_w;
  assign coff_w = rgb_offset_select ? `VSL_OFFSET : 11'h000;
  assign dac_next.ch0 = ch0_w + `VSL_OFFSET;
  assign dac_next.ch1 = ch1_w + coff_w;
  assign dac_next.ch2 = ch2_w + coff_w;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_reg <= '0;
      fs_reg <= 1'b0;
    end
    else
    begin
      dac_reg <= dac_next;
      fs_reg <= fullscale_range_select;
    end
  end

  // outputs straight from flops
  assign dac_out = dac_reg;
  assign fullscale_range_out = fs_reg;
  assign line_type = ltype_reg;
  assign sync_state = state_reg;
  assign field_second = field2_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // a plain line pulse, not a frame restart
  sequence s_line_begin;
    line_start && !frame_start;
  endsequence

  // hd line opened and left running for two pixels
  sequence s_hd_line_open;
    line_start && mode_reg == vsl_pkg::MODE_HD && mode_next == vsl_pkg::MODE_HD ##1
      !restart_w [*2];
  endsequence

  // line counter, line type, horizontal sequencer, generated level and pass decision
  a_line_wrap: assert property ((s_line_begin and (line_reg >= frame_w)) |=>
    line_reg == `VSL_LINE_RST) else $error("line counter did not wrap");
  a_line_step: assert property ((s_line_begin and (line_reg < frame_w)) |=>
    line_reg == $past(line_reg) + 11'h001) else $error("line counter did not step");
  a_frame_line_one: assert property (frame_start |=> line_reg == `VSL_LINE_RST)
    else $error("frame start did not force line one");
  a_state_restart: assert property (line_start |=> state_reg == `VSL_ST_FIRST &&
    hcount_reg == 12'h000) else $error("state not restarted at line start");
  a_hd_first_dur: assert property (s_hd_line_open |=> state_reg == 4'h2)
    else $error("hd first state not two pixels");
  a_hd_broad_start: assert property (mode_reg == vsl_pkg::MODE_HD && frame_start |=>
    ltype_reg == vsl_pkg::HD_BROAD_BROAD) else $error("hd line one not broad");
  a_hd_pass_gate: assert property (mode_reg == vsl_pkg::MODE_HD &&
    ltype_reg == vsl_pkg::HD_FULL_SYNC && !vbi_video_pass_enable |-> !pass_w)
    else $error("hd full sync passed video");
  a_sd_pic_pass: assert property (mode_reg == vsl_pkg::MODE_SD && sd_pic_w &&
    st5_w |-> pass_w) else $error("sd picture state not passed");
  a_sd_sync_edge: assert property (mode_reg == vsl_pkg::MODE_SD && line_start |=>
    lvl_low_w) else $error("sd line did not open with sync");
  // converter codes
  a_vesa_pass: assert property (mode_reg == vsl_pkg::MODE_VESA |=>
    dac_reg.ch0 == {1'b0, $past(video_in.luma)} + `VSL_OFFSET)
    else $error("vesa output not from video bus");
  a_yuv_chroma: assert property (!rgb_offset_select && pass_w |=>
    dac_reg.ch1 == {1'b0, $past(video_in.cb)}) else $error("chroma offset in ypbpr");
  a_rgb_chroma: assert property (rgb_offset_select && pass_w |=>
    dac_reg.ch1 == {1'b0, $past(video_in.cb)} + `VSL_OFFSET)
    else $error("chroma offset missing in rgb");
  a_hd_gen_high: assert property (mode_reg == vsl_pkg::MODE_HD &&
    state_reg == `VSL_ST_FIRST |=> dac_reg.ch0 == $past(luma_amp.high) + `VSL_OFFSET)
    else $error("hd sync tip not from high amplitude");
  a_sd_gen_low: assert property (mode_reg == vsl_pkg::MODE_SD &&
    state_reg == `VSL_ST_FIRST |=> dac_reg.ch0 == $past(luma_amp.low) + `VSL_OFFSET)
    else $error("sd sync not from low amplitude");
endmodule : vsl_line_sequencer

// *** vsl_video_src.sv ***
// ****************************************
// upstream video source model
// ****************************************
module vsl_video_src (
  // clock
  input wire logic sys_clk,
  // video bus towards the sequencer
  output vsl_pkg::vsl_video_s video_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] pix_reg = 10'h000;
  // new pixel on every falling edge so a stale sample never matches
  always @(negedge sys_clk)
  begin
    pix_reg <= pix_reg + 10'h007;
  end
  // three channels moving apart from each other
  assign video_out = '{pix_reg, ~pix_reg, pix_reg ^ 10'h155};
endmodule : vsl_video_src

// *** tb_vsl_line_sequencer.sv ***
`include "vsl_regs.svh"
// ****************************************
// bench for the line sequencer
// ****************************************
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module tb_vsl_line_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int hp_a = 6, hp_b = 10, hp_c = 6, hp_d = 14, hp_e = 12;
  localparam int hp_g = 22, hp_k = 4, hp_k1 = 4, hp_t = 40;
  localparam int wd_cycles = 40000;
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst_b, line_start, frame_start, pass_en, rgb, fs_sel, fs_out, field_second;
  logic [3:0] fmt;
  logic [3:0] sync_state;
  vsl_pkg::vsl_hparam_s hparam;
  vsl_pkg::vsl_amp_s luma_amp, chroma_amp;
  vsl_pkg::vsl_video_s video_in, vid_q;
  vsl_pkg::vsl_dac_s dac_out;
  vsl_pkg::vsl_ltype_e line_type;
  int err_total = 0;
  int checks_done = 0;
  // breakpoint tables and their line types
  int hd_bp[11] = '{6, 7, 21, 561, 563, 564, 568, 569, 584, 1124, 1126};
  int sd_bp[15] = '{4, 7, 10, 20, 263, 264, 266, 267, 269, 270, 272, 273, 282, 283, 526};
  vsl_pkg::vsl_ltype_e hd_lt[11] = '{vsl_pkg::HD_BROAD_BROAD, vsl_pkg::HD_SYNC_SYNC,
    vsl_pkg::HD_FULL_SYNC, vsl_pkg::HD_ACTIVE, vsl_pkg::HD_FULL_SYNC, vsl_pkg::HD_SYNC_BROAD,
    vsl_pkg::HD_BROAD_BROAD, vsl_pkg::HD_BROAD_SYNC, vsl_pkg::HD_FULL_SYNC, vsl_pkg::HD_ACTIVE,
    vsl_pkg::HD_FULL_SYNC};
  vsl_pkg::vsl_ltype_e sd_lt[15] = '{vsl_pkg::SD_EQ_EQ, vsl_pkg::SD_BROAD_BROAD,
    vsl_pkg::SD_EQ_EQ, vsl_pkg::SD_FULL_SYNC, vsl_pkg::SD_ACTIVE, vsl_pkg::SD_PICTURE_THEN_EQ,
    vsl_pkg::SD_EQ_EQ, vsl_pkg::SD_EQ_BROAD, vsl_pkg::SD_BROAD_BROAD, vsl_pkg::SD_BROAD_EQ,
    vsl_pkg::SD_EQ_EQ, vsl_pkg::SD_FULL_EQ, vsl_pkg::SD_FULL_SYNC,
    vsl_pkg::SD_SYNC_THEN_PICTURE, vsl_pkg::SD_ACTIVE};
  // pixel clock
  always #2 sys_clk = ~sys_clk;
  // video value the design takes at each rising edge
  always @(posedge sys_clk) vid_q <= video_in;
  vsl_video_src src (.sys_clk(sys_clk), .video_out(video_in));
  vsl_line_sequencer dut (.sys_clk(sys_clk), .rst_b(rst_b), .format_select(fmt),
    .vbi_video_pass_enable(pass_en), .rgb_offset_select(rgb),
    .fullscale_range_select(fs_sel), .hparam(hparam), .luma_amp(luma_amp),
    .chroma_amp(chroma_amp), .line_start(line_start), .frame_start(frame_start),
    .video_in(video_in), .dac_out(dac_out), .fullscale_range_out(fs_out),
    .line_type(line_type), .sync_state(sync_state), .field_second(field_second));
  // ****************************************
  // expectations
  // ****************************************
  function automatic int dur(input bit sd, input bit eq, input int s);
    int h[13];
    if (!sd)
      h = '{0, 2, hp_c - 4, 4, hp_e - hp_c - 2, hp_t - hp_e - hp_b, hp_b - hp_a - 2, 4,
        hp_a - 4, 2, 0, 0, 0};
    else if (!eq)
      h = '{0, 1, hp_a, 2, hp_d - hp_a - 3, hp_t - hp_d - hp_k, hp_k - 1, 1, 0, 0, 0, 0, 0};
    else
      h = '{0, 1, hp_a, 2, hp_d - hp_a - 3, hp_g - hp_d - hp_k1, hp_k - 1, 1, 1, hp_c, 2,
        hp_g - hp_c - 4, 1};
    return h[s];
  endfunction : dur
  function automatic logic [10:0] pick(input vsl_pkg::vsl_amp_s a, input int lv);
    return (lv == 2) ? a.high : (lv == 1) ? a.low : a.blank;
  endfunction : pick
  function automatic vsl_pkg::vsl_dac_s exp_dac(input vsl_pkg::vsl_ltype_e t, input int s);
    logic pas;
    int lv;
    vsl_pkg::vsl_dac_s r;
    pas = (fmt != `VSL_FMT_1080I && fmt != `VSL_FMT_525I) || (s == 5 && (t == vsl_pkg::HD_ACTIVE
      || t == vsl_pkg::SD_ACTIVE || t == vsl_pkg::SD_SYNC_THEN_PICTURE
      || t == vsl_pkg::SD_PICTURE_THEN_EQ)) || (pass_en && ((s == 5 && t == vsl_pkg::HD_FULL_SYNC)
      || ((s == 4 || s == 5) && t == vsl_pkg::SD_FULL_SYNC)));
    if (fmt == `VSL_FMT_1080I)
      lv = (s == 1) ? 2 : (s == 9) ? 1 : 0;
    else
      lv = (s <= 2 || (t == vsl_pkg::SD_PICTURE_THEN_EQ && (s == 8 || s == 9))) ? 1 : 0;
    r.ch0 = (pas ? {1'b0, vid_q.luma} : pick(luma_amp, lv)) + `VSL_OFFSET;
    r.ch1 = (pas ? {1'b0, vid_q.cb} : pick(chroma_amp, lv)) + (rgb ? `VSL_OFFSET : 11'h000);
    r.ch2 = (pas ? {1'b0, vid_q.cr} : pick(chroma_amp, lv)) + (rgb ? `VSL_OFFSET : 11'h000);
    return r;
  endfunction : exp_dac
  // ****************************************
  // access tasks
  // ****************************************
  task automatic pulse(input bit fr);
    @(negedge sys_clk);
    if (fr)
      frame_start = 1'b1;
    else
      line_start = 1'b1;
    @(negedge sys_clk);
    frame_start = 1'b0;
    line_start = 1'b0;
  endtask : pulse
  task automatic sweep(input bit sd);
    int fr, ln;
    vsl_pkg::vsl_ltype_e ex;
    fr = sd ? 525 : 1125;
    pulse(1'b1);
    ln = 1;
    for (int i = 0; i <= fr; i++)
    begin
      for (int j = (sd ? 14 : 10); j >= 0; j--)
        if ((sd ? sd_bp[j] : hd_bp[j]) > ln) ex = sd ? sd_lt[j] : hd_lt[j];
      `CHK("line_type", ex, line_type);
      `CHK("field_second", 1'(ln > (sd ? 263 : 563)), field_second);
      pulse(1'b0);
      ln = (ln >= fr) ? 1 : ln + 1;
    end
    $display("test sweep %0d done", sd);
  endtask : sweep
  task automatic walk(input bit sd, input vsl_pkg::vsl_ltype_e t, input int ln, input bit pe);
    int ps;
    pass_en = pe;
    pulse(1'b1);
    repeat (ln - 1) pulse(1'b0);
    `CHK("line_type", t, line_type);
    ps = 0;
    for (int s = 1; s <= 12; s++)
    begin
      for (int i = 0; i < dur(sd, t == vsl_pkg::SD_PICTURE_THEN_EQ, s); i++)
      begin
        `CHK("sync_state", 4'(s), sync_state);
        if (ps != 0) `CHK("dac_out", exp_dac(t, ps), dac_out);
        ps = s;
        @(negedge sys_clk);
      end
    end
    $display("test walk %0d done", t);
  endtask : walk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    fmt = `VSL_FMT_VESA;
    line_start = 1'b0;
    frame_start = 1'b0;
    pass_en = 1'b0;
    rgb = 1'b0;
    fs_sel = 1'b0;
    hparam = '{12'(hp_a), 12'(hp_b), 12'(hp_c), 12'(hp_d), 12'(hp_e), 12'(hp_g), 12'(hp_k),
      12'(hp_k1), 12'(hp_t)};
    luma_amp = '{11'h040, 11'h004, 11'h3A0};
    chroma_amp = '{11'h200, 11'h110, 11'h2F0};
    repeat (4) @(negedge sys_clk);
    `CHK("reset outputs", {33'h0, 1'b0, vsl_pkg::HD_BROAD_BROAD, 4'h1, 1'b0},
      {dac_out, fs_out, line_type, sync_state, field_second});
    rst_b = 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      rgb = r[0];
      fs_sel = r[0];
      repeat (2) @(negedge sys_clk);
      `CHK("fullscale_range_out", fs_sel, fs_out);
      repeat (4)
      begin
        `CHK("dac_out", exp_dac(vsl_pkg::HD_ACTIVE, 1), dac_out);
        @(negedge sys_clk);
      end
    end
    $display("test vesa done");
    fmt = `VSL_FMT_1080I;
    sweep(1'b0);
    walk(1'b0, vsl_pkg::HD_ACTIVE, 21, 1'b0);
    walk(1'b0, vsl_pkg::HD_FULL_SYNC, 7, 1'b0);
    walk(1'b0, vsl_pkg::HD_FULL_SYNC, 7, 1'b1);
    rgb = 1'b0;
    fmt = `VSL_FMT_525I;
    sweep(1'b1);
    walk(1'b1, vsl_pkg::SD_ACTIVE, 20, 1'b0);
    walk(1'b1, vsl_pkg::SD_FULL_SYNC, 10, 1'b0);
    walk(1'b1, vsl_pkg::SD_FULL_SYNC, 10, 1'b1);
    walk(1'b1, vsl_pkg::SD_PICTURE_THEN_EQ, 263, 1'b0);
    walk(1'b1, vsl_pkg::SD_SYNC_THEN_PICTURE, 282, 1'b0);
    test_done();
  end
  // watchdog against a hung sequence
  initial
  begin
    #(wd_cycles * 4);
    err_total++;
    $display("watchdog expired");
    test_done();
  end
endmodule : tb_vsl_line_sequencer
